// ---- core/ssuc_ctrl.v ----
// Purpose: Masked signal/upload control word plus two sequencer tasks
// Assumes: Synchronous inputs, one memory read port per task
// Notes:   Read data stands one cycle after the read strobe
//          Upload pulses come only from the upload command
`include "ssuc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module ssuc_ctrl (
	input  wire        mclk,
	input  wire        rst,
	input  wire [8:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire [15:0] ext_events,
	output wire [1:0]  mem_req,
	output wire [63:0] mem_addr,
	input  wire [1:0]  mem_ack,
	input  wire [63:0] mem_rdata,
	output reg  [10:0] refresh_sections,
	output reg         refresh_dual_init,
	output reg         refresh_shared,
	output reg  [1:0]  task_enable,
	output reg  [4:0]  task_flags
);

	// ==========================================================
	// Decoding helpers
	function cond_met;
		input [`SSUC_EV_W-1:0] mask;
		input [`SSUC_EV_W-1:0] ev;
		input                  oan;
		input                  inv;
		reg   [`SSUC_EV_W-1:0] hit;
		begin
			hit = mask & ev;
			cond_met = (oan ? (|hit) : (hit == mask)) ^ inv;
		end
	endfunction

	function task_hit;
		input [8:0] addr;
		input [8:0] idx;
		input [8:0] ofs;
		begin
			task_hit = (addr == `SSUC_OFS_TASK0 + idx * `SSUC_TASK_STRIDE + ofs);
		end
	endfunction

	// ==========================================================
	// State
	reg  [15:0] ctrl2_reg;
	reg  [15:0] ctrl2_next;
	reg  [1:0]  en_reg;
	reg  [1:0]  en_next;
	reg  [1:0]  tmo_flag_reg;
	reg  [1:0]  tmo_flag_next;
	reg  [10:0] upl_all;
	reg  [4:0]  set_all;
	reg  [4:0]  clr_all;
	reg  [31:0] rd_next;
	wire [`SSUC_EV_W-1:0] events;
	wire [15:0] wmask;
	wire        wr_ctrl1;
	wire        wr_ctrl2;
	wire        wr_status;
	wire [1:0]  t_stop;
	wire [1:0]  t_tmo;
	wire [21:0] t_upl;
	wire [9:0]  t_set;
	wire [9:0]  t_clr;
	wire [63:0] t_pc;
	wire [63:0] t_page;
	wire [63:0] t_hbi;
	wire [63:0] t_tmov;
	wire [3:0]  t_state;
	wire [7:0]  jflags;

	assign wmask     = reg_wdata[31:`SSUC_MASK_LSB];
	assign wr_ctrl1  = reg_wr && (reg_addr == `SSUC_OFS_CTRL1);
	assign wr_ctrl2  = reg_wr && (reg_addr == `SSUC_OFS_CTRL2);
	assign wr_status = reg_wr && (reg_addr == `SSUC_OFS_STATUS);
	assign events    = {ctrl2_reg[`SSUC_FLAG_MSB:`SSUC_FLAG_LSB], ext_events};
	// Selects beyond the five flags read as clear
	assign jflags    = {3'b000, ctrl2_reg[`SSUC_FLAG_MSB:`SSUC_FLAG_LSB]};

	// ==========================================================
	// Sequencer tasks
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_task
			reg  [1:0]  st_reg;
			reg  [31:0] pc_reg;
			reg  [31:0] page_reg;
			reg  [31:0] hbi_reg;
			reg  [31:0] tmo_reg;
			reg  [31:0] cnt_reg;
			reg  [31:0] cmd_reg;
			reg         req_reg;
			wire [3:0]  op;
			wire        in_exec;
			wire        wait_ok;
			wire        jump_ok;
			wire        expire;
			wire        is_upload;
			wire        is_setsig;
			wire        is_clrsig;
			wire        is_stop;
			localparam [8:0] TIDX = g;

			assign op      = cmd_reg[`SSUC_OP_MSB:`SSUC_OP_LSB];
			assign in_exec = (st_reg == `SSUC_ST_EXEC);
			// Opcode decode
			assign is_upload = in_exec && (op == `SSUC_OP_UPLOAD);
			assign is_setsig = in_exec && (op == `SSUC_OP_SETSIG);
			assign is_clrsig = in_exec && (op == `SSUC_OP_CLRSIG);
			assign is_stop   = in_exec && (op == `SSUC_OP_STOP);
			// Event wait, AND or OR over the selected events, optional inversion
			assign wait_ok = cond_met(cmd_reg[`SSUC_EV_W-1:0], events,
				cmd_reg[`SSUC_CMD_OAN], cmd_reg[`SSUC_CMD_INV]);
			// Conditional jump on one task flag
			assign jump_ok = jflags[cmd_reg[24:22]]
				^ cmd_reg[`SSUC_CMD_JINV];
			assign expire  = (st_reg == `SSUC_ST_WAIT) && !wait_ok && (tmo_reg != 32'h0)
				&& (cnt_reg + 32'h1 >= tmo_reg);

			assign t_tmo[g]  = expire;
			assign t_stop[g] = expire || is_stop;
			// Sections from the command ORed with the control word, bit 7 dropped
			assign t_upl[g*11 +: 11] = is_upload ?
				((cmd_reg[10:0] | ctrl2_reg[10:0]) & 11'h77F) : 11'h000;
			assign t_set[g*5 +: 5] = is_setsig ?
				cmd_reg[4:0] : 5'h00;
			assign t_clr[g*5 +: 5] = is_clrsig ?
				cmd_reg[4:0] : 5'h00;
			assign mem_req[g]          = req_reg;
			assign mem_addr[g*32 +: 32] = pc_reg;
			assign t_pc[g*32 +: 32]    = pc_reg;
			assign t_page[g*32 +: 32]  = page_reg;
			assign t_hbi[g*32 +: 32]   = hbi_reg;
			assign t_tmov[g*32 +: 32]  = tmo_reg;
			assign t_state[g*2 +: 2]   = st_reg;

			// Per-task register set
			always @(posedge mclk) begin
				if (rst) begin
					page_reg <= `SSUC_WORD_RST;
					hbi_reg  <= `SSUC_WORD_RST;
					tmo_reg  <= `SSUC_WORD_RST;
				end else begin
					if (task_hit(reg_addr, TIDX, `SSUC_OFS_TPAGE) && reg_wr)
						page_reg <= reg_wdata;
					if (task_hit(reg_addr, TIDX, `SSUC_OFS_THBI) && reg_wr)
						hbi_reg <= reg_wdata;
					if (task_hit(reg_addr, TIDX, `SSUC_OFS_TTMO) && reg_wr)
						tmo_reg <= reg_wdata;
				end
			end

			always @(posedge mclk) begin
				if (rst) begin
					st_reg  <= `SSUC_ST_IDLE;
					pc_reg  <= `SSUC_WORD_RST;
					cnt_reg <= `SSUC_WORD_RST;
					cmd_reg <= `SSUC_WORD_RST;
					req_reg <= 1'b0;
				end else begin
					case (st_reg)
						`SSUC_ST_IDLE: begin
							// Start on enable
							if (en_reg[g]) begin
								st_reg  <= `SSUC_ST_FETCH;
								req_reg <= 1'b1;
							end
						end
						`SSUC_ST_FETCH: begin
							// Command word from system memory
							if (mem_ack[g]) begin
								cmd_reg <= mem_rdata[g*32 +: 32];
								pc_reg  <= pc_reg + 32'h4;
								req_reg <= 1'b0;
								st_reg  <= `SSUC_ST_EXEC;
							end
						end
						`SSUC_ST_EXEC: begin
							cnt_reg <= `SSUC_WORD_RST;
							if (op == `SSUC_OP_JUMP && jump_ok)
								pc_reg <= {page_reg[31:22], cmd_reg[19:0], 2'b00};
							if (!en_reg[g] || op == `SSUC_OP_STOP) begin
								st_reg <= `SSUC_ST_IDLE;
							end else if (op == `SSUC_OP_PAUSE) begin
								st_reg <= `SSUC_ST_WAIT;
							end else begin
								st_reg  <= `SSUC_ST_FETCH;
								req_reg <= 1'b1;
							end
						end
						`SSUC_ST_WAIT: begin
							cnt_reg <= cnt_reg + 32'h1;
							if (!en_reg[g] || expire) begin
								st_reg <= `SSUC_ST_IDLE;
							end else if (wait_ok) begin
								st_reg  <= `SSUC_ST_FETCH;
								req_reg <= 1'b1;
							end
						end
						default: begin
							st_reg  <= `SSUC_ST_IDLE;
							req_reg <= 1'b0;
						end
					endcase
					// Software load of the program address
					if (task_hit(reg_addr, TIDX, `SSUC_OFS_TADDR) && reg_wr)
						pc_reg <= reg_wdata;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Control word and task flags
	always @* begin
		upl_all = t_upl[10:0] | t_upl[21:11];
		set_all = t_set[4:0] | t_set[9:5];
		clr_all = t_clr[4:0] | t_clr[9:5];
		ctrl2_next = ctrl2_reg;
		if (wr_ctrl2)
			ctrl2_next = (ctrl2_reg & ~wmask) | (reg_wdata[15:0] & wmask);
		// Task clear, then task set: a set never loses
		ctrl2_next[`SSUC_FLAG_MSB:`SSUC_FLAG_LSB] =
			(ctrl2_next[`SSUC_FLAG_MSB:`SSUC_FLAG_LSB] & ~clr_all) | set_all;
		ctrl2_next[`SSUC_RSVD_BIT] = 1'b0;
	end

	// ==========================================================
	// Task enables
	always @* begin
		en_next = en_reg & ~t_stop;
		// Host write beats a hardware stop in the same cycle
		if (wr_ctrl1) begin
			if (wmask[`SSUC_EN1_BIT])
				en_next[1] = reg_wdata[`SSUC_EN1_BIT];
			if (wmask[`SSUC_EN0_BIT])
				en_next[0] = reg_wdata[`SSUC_EN0_BIT];
		end
	end

	// ==========================================================
	// Timeout flags
	always @* begin
		tmo_flag_next = tmo_flag_reg;
		// Write of one clears; a new timeout wins
		if (wr_status)
			tmo_flag_next = tmo_flag_reg & ~reg_wdata[1:0];
		tmo_flag_next = tmo_flag_next | t_tmo;
	end

	// ==========================================================
	// Read mux
	always @* begin
		rd_next = 32'h00000000;
		// Unmapped addresses read as zero
		if (reg_addr == `SSUC_OFS_CTRL1) begin
			rd_next[`SSUC_EN1_BIT] = en_reg[1];
			rd_next[`SSUC_EN0_BIT] = en_reg[0];
		end else if (reg_addr == `SSUC_OFS_CTRL2) begin
			rd_next = {16'h0000, ctrl2_reg};
		end else if (reg_addr == `SSUC_OFS_STATUS) begin
			rd_next = {24'h000000, t_state, 2'b00, tmo_flag_reg};
		end else if (task_hit(reg_addr, 9'h000, `SSUC_OFS_TADDR)) begin
			rd_next = t_pc[31:0];
		end else if (task_hit(reg_addr, 9'h000, `SSUC_OFS_TPAGE)) begin
			rd_next = t_page[31:0];
		end else if (task_hit(reg_addr, 9'h000, `SSUC_OFS_THBI)) begin
			rd_next = t_hbi[31:0];
		end else if (task_hit(reg_addr, 9'h000, `SSUC_OFS_TTMO)) begin
			rd_next = t_tmov[31:0];
		end else if (task_hit(reg_addr, 9'h001, `SSUC_OFS_TADDR)) begin
			rd_next = t_pc[63:32];
		end else if (task_hit(reg_addr, 9'h001, `SSUC_OFS_TPAGE)) begin
			rd_next = t_page[63:32];
		end else if (task_hit(reg_addr, 9'h001, `SSUC_OFS_THBI)) begin
			rd_next = t_hbi[63:32];
		end else if (task_hit(reg_addr, 9'h001, `SSUC_OFS_TTMO)) begin
			rd_next = t_tmov[63:32];
		end
	end

	// ==========================================================
	// Registers and outputs
	always @(posedge mclk) begin
		if (rst) begin
			ctrl2_reg         <= `SSUC_CTRL2_RST;
			en_reg            <= `SSUC_EN_RST;
			tmo_flag_reg      <= 2'h0;
			reg_rdata         <= `SSUC_WORD_RST;
			refresh_sections  <= 11'h000;
			refresh_dual_init <= 1'b0;
			refresh_shared    <= 1'b0;
			task_enable       <= `SSUC_EN_RST;
			task_flags        <= 5'h00;
		end else begin
			ctrl2_reg    <= ctrl2_next;
			en_reg       <= en_next;
			tmo_flag_reg <= tmo_flag_next;
			reg_rdata    <= reg_rd ? rd_next : 32'h00000000;
			// One pulse per selected section
			refresh_sections  <= upl_all;
			refresh_dual_init <= upl_all[`SSUC_UPL_PORTB] & upl_all[`SSUC_UPL_PORTA];
			refresh_shared    <= |upl_all[`SSUC_UPL_DMA3:`SSUC_UPL_EXTBUS];
			// Registered copies of enables and flags
			task_enable       <= en_next;
			task_flags        <= ctrl2_next[`SSUC_FLAG_MSB:`SSUC_FLAG_LSB];
		end
	end

endmodule

`default_nettype wire

// ---- include/ssuc_map.vh ----
// Purpose: Constants of the sequencer signal and upload control block
// Assumes: Byte addresses on a 9-bit register port
// Notes:   Definitions only
`ifndef SSUC_MAP_VH
`define SSUC_MAP_VH

// ==========================================================
// Register offsets
`define SSUC_OFS_CTRL1      9'h0FC
`define SSUC_OFS_CTRL2      9'h100
`define SSUC_OFS_TASK0      9'h104
`define SSUC_TASK_STRIDE    9'h010
`define SSUC_OFS_TADDR      9'h000
`define SSUC_OFS_TPAGE      9'h004
`define SSUC_OFS_THBI       9'h008
`define SSUC_OFS_TTMO       9'h00C
`define SSUC_OFS_STATUS     9'h124

// ==========================================================
// Field positions
`define SSUC_MASK_LSB       16
`define SSUC_FLAG_MSB       15
`define SSUC_FLAG_LSB       11
`define SSUC_RSVD_BIT       7
`define SSUC_EN1_BIT        13
`define SSUC_EN0_BIT        12
`define SSUC_UPL_PORTB      10
`define SSUC_UPL_PORTA      9
`define SSUC_UPL_EXTBUS     1
`define SSUC_UPL_DMA1       2
`define SSUC_UPL_DMA3       4

// ==========================================================
// Reset values
`define SSUC_CTRL2_RST      16'h0000
`define SSUC_EN_RST         2'h0
`define SSUC_WORD_RST       32'h00000000

// ==========================================================
// Command word
`define SSUC_OP_MSB         31
`define SSUC_OP_LSB         28
`define SSUC_OP_CLRSIG      4'h0
`define SSUC_OP_PAUSE       4'h1
`define SSUC_OP_UPLOAD      4'h2
`define SSUC_OP_SETSIG      4'h3
`define SSUC_OP_JUMP        4'h4
`define SSUC_OP_STOP        4'h5
`define SSUC_CMD_INV        27
`define SSUC_CMD_OAN        26
`define SSUC_CMD_JINV       25
`define SSUC_CMD_JSEL_LSB   22
`define SSUC_EV_W           21

// ==========================================================
// Task states
`define SSUC_ST_IDLE        2'h0
`define SSUC_ST_FETCH       2'h1
`define SSUC_ST_EXEC        2'h2
`define SSUC_ST_WAIT        2'h3

`endif

// ---- tb/ssuc_ctrl_sva.sv ----
// Purpose: Port-level assertions for ssuc_ctrl
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bind statement follows the module
`timescale 1ns/1ps
`default_nettype none

module ssuc_ctrl_sva (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [8:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [1:0]  mem_req,
	input wire logic [63:0] mem_addr,
	input wire logic [1:0]  mem_ack,
	input wire logic [10:0] refresh_sections,
	input wire logic        refresh_dual_init,
	input wire logic        refresh_shared,
	input wire logic [1:0]  task_enable,
	input wire logic [4:0]  task_flags
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ==========================================================
	// Sequences
	sequence s_rd_ctrl2;
		reg_rd && reg_addr == 9'h100;
	endsequence
	sequence s_wr_quiet;
		reg_wr && reg_addr == 9'h100 && task_enable == 2'h0 && mem_req == 2'h0
			&& mem_ack == 2'h0 && $past(mem_ack) == 2'h0;
	endsequence

	// ==========================================================
	// Properties
	property p_mask_zero;
		s_rd_ctrl2 |=> reg_rdata[31:16] == 16'h0000 && !reg_rdata[7];
	endproperty
	property p_flag_read;
		s_rd_ctrl2 |=> reg_rdata[15:11] == $past(task_flags);
	endproperty
	property p_masked_write;
		s_wr_quiet |=> task_flags == (($past(task_flags) & ~$past(reg_wdata[31:27]))
			| ($past(reg_wdata[15:11]) & $past(reg_wdata[31:27])));
	endproperty
	property p_en_write;
		reg_wr && reg_addr == 9'h0FC && reg_wdata[28] |=> task_enable[0] == $past(reg_wdata[12]);
	endproperty
	property p_reset_clear;
		$fell(rst) |-> task_enable == 2'h0 && task_flags == 5'h00 && mem_req == 2'h0;
	endproperty
	property p_idle_no_fetch;
		!task_enable[0] && !mem_req[0] |=> !mem_req[0];
	endproperty
	property p_req_hold;
		mem_req[0] && !mem_ack[0] |=> mem_req[0];
	endproperty
	property p_pc_step;
		mem_req[0] && mem_ack[0] && !reg_wr |=> mem_addr[31:0] == $past(mem_addr[31:0]) + 32'h4;
	endproperty
	property p_dual;
		refresh_dual_init == (refresh_sections[10] && refresh_sections[9]);
	endproperty
	property p_shared;
		refresh_shared == (|refresh_sections[4:1]);
	endproperty
	property p_pulse;
		|refresh_sections |-> !refresh_sections[7] ##1 refresh_sections == 11'h000;
	endproperty

	a_mask_zero: assert property (p_mask_zero) else $error("mask or reserved bit read nonzero");
	a_flag_read: assert property (p_flag_read) else $error("flag readback differs");
	a_masked_write: assert property (p_masked_write) else $error("masked write wrong");
	a_en_write: assert property (p_en_write) else $error("enable write lost");
	a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");
	a_idle_no_fetch: assert property (p_idle_no_fetch) else $error("fetch while disabled");
	a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
	a_pc_step: assert property (p_pc_step) else $error("program address not stepped");
	a_dual: assert property (p_dual) else $error("dual setup refresh wrong");
	a_shared: assert property (p_shared) else $error("shared refresh wrong");
	a_pulse: assert property (p_pulse) else $error("refresh pulse wrong");
endmodule

bind ssuc_ctrl ssuc_ctrl_sva u_sva (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
	.refresh_sections(refresh_sections), .refresh_dual_init(refresh_dual_init),
	.refresh_shared(refresh_shared), .task_enable(task_enable), .task_flags(task_flags));

`default_nettype wire

// ---- tb/ssuc_ctrl_test.sv ----
// Purpose: Self-checking bench for ssuc_ctrl
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   Control word rows in a table, task cases after it
`timescale 1ns/1ps
`default_nettype none

module ssuc_ctrl_test;
	logic        mclk;
	logic        rst;
	logic [8:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [1:0]  mem_req;
	logic [63:0] mem_addr;
	logic [1:0]  mem_ack;
	logic [63:0] mem_rdata;
	logic [10:0] refresh_sections;
	logic        refresh_dual_init;
	logic        refresh_shared;
	logic [1:0]  task_enable;
	logic [4:0]  task_flags;
	logic [15:0] ext_events;
	logic [12:0] seen;
	logic [31:0] d;
	int          miscompares;
	int          tests_run;
	// Write word beside expected readback
	logic [63:0] rows [0:5] = '{64'hFFFFFFFF_0000FF7F, 64'h00010000_0000FF7E,
		64'hF8000000_0000077E, 64'h0000FFFF_0000077E, 64'h04800000_0000037E,
		64'h80008000_0000837E};

	ssuc_ctrl u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_events(ext_events),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.refresh_sections(refresh_sections), .refresh_dual_init(refresh_dual_init),
		.refresh_shared(refresh_shared), .task_enable(task_enable), .task_flags(task_flags));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [8:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(negedge mclk);
	endtask

	task rd(input logic [8:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
	endtask

	// Answer one fetch, then gather refresh pulses
	task serve(input int g, input logic [31:0] ea, input logic [31:0] cmd);
		int n;
		n = 0;
		while (mem_req[g] !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		chk("fetch_addr", mem_addr[g*32+:32], ea);
		@(posedge mclk);
		mem_ack[g] <= 1'b1;
		mem_rdata[g*32+:32] <= cmd;
		@(posedge mclk);
		mem_ack[g] <= 1'b0;
		seen = 13'h0000;
		repeat (6) begin
			@(negedge mclk);
			seen = seen | {refresh_dual_init, refresh_shared, refresh_sections};
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#(50 * 4000);
		miscompares++;
		conclude;
	end

	initial begin
		rst = 1'b1;
		reg_addr = 9'h000;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mem_ack = 2'h0;
		mem_rdata = 64'h0;
		ext_events = 16'h0000;
		miscompares = 0;
		tests_run = 0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(9'h100, d);
		chk("ctrl2_rst", d, 32'h0);
		chk("en_rst", task_enable, 2'h0);
		foreach (rows[i]) begin
			wr(9'h100, rows[i][63:32]);
			rd(9'h100, d);
			chk("ctrl2", d, rows[i][31:0]);
			chk("flags", task_flags, rows[i][15:11]);
		end
		$display("control word rows done");
		wr(9'h1FC, 32'hFFFFFFFF);
		rd(9'h1FC, d);
		chk("unmapped", d, 32'h0);
		wr(9'h100, 32'h07FF0000);
		wr(9'h104, 32'h00000040);
		wr(9'h0FC, 32'h10001000);
		chk("en0", task_enable, 2'h1);
		serve(0, 32'h40, 32'h20000603);
		chk("upl_a", seen, 13'h1E03);
		serve(0, 32'h44, 32'h200000F4);
		chk("upl_b", seen, 13'h0874);
		wr(9'h100, 32'h01080108);
		serve(0, 32'h48, 32'h20000000);
		chk("upl_c", seen, 13'h0908);
		$display("upload tests done");
		serve(0, 32'h4C, 32'h30000007);
		serve(0, 32'h50, 32'h00000010);
		rd(9'h100, d);
		chk("sig", d, 32'h00003908);
		serve(0, 32'h54, 32'h10000001);
		chk("pause_hold", mem_req, 2'h0);
		@(posedge mclk);
		ext_events <= 16'h0001;
		serve(0, 32'h58, 32'h40C00040);
		serve(0, 32'h5C, 32'h40000040);
		serve(0, 32'h100, 32'h50000000);
		$display("wait and jump tests done");
		repeat (10) @(negedge mclk);
		chk("stop0", task_enable, 2'h0);
		chk("nofetch", mem_req, 2'h0);
		wr(9'h114, 32'h00000080);
		wr(9'h0FC, 32'h20002000);
		chk("en1", task_enable, 2'h2);
		serve(1, 32'h80, 32'h50000000);
		chk("stop1", task_enable, 2'h0);
		wr(9'h120, 32'h00000005);
		wr(9'h0FC, 32'h20002000);
		serve(1, 32'h84, 32'h10000002);
		repeat (4) @(negedge mclk);
		chk("tmo_en", task_enable, 2'h0);
		rd(9'h124, d);
		chk("tmo_flag", d, 32'h00000002);
		wr(9'h124, 32'h00000002);
		rd(9'h124, d);
		chk("tmo_clr", d, 32'h00000000);
		wr(9'h118, 32'h12340000);
		rd(9'h118, d);
		chk("page1", d, 32'h12340000);
		rd(9'h108, d);
		chk("page0", d, 32'h00000000);
		$display("task tests done");
		wr(9'h0FC, 32'h30003000);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("en_rerst", task_enable, 2'h0);
		chk("req_rerst", mem_req, 2'h0);
		rd(9'h100, d);
		chk("ctrl2_rerst", d, 32'h0);
		$display("reset test done");
		conclude;
	end
endmodule

`default_nettype wire
